// ==== dv/ivt_core_model.sv ====
`timescale 1ns/1ps
module ivt_core_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic irq_valid,
  output logic      irq_accept
);
  int wait_n;

  // Core takes a shown vector after a random think time, one-cycle pulse
  always @(posedge mclk) begin
    if (rst || !irq_valid || irq_accept) begin
      irq_accept <= 1'b0;
      wait_n     <= $urandom_range(0, 4);
    end else if (wait_n == 0) begin
      irq_accept <= 1'b1;
    end else begin
      wait_n <= wait_n - 1;
    end
  end
endmodule

// ==== dv/ivt_prio_chk.sv ====
`timescale 1ns/1ps
module ivt_prio_chk (
  input wire logic               mclk,
  input wire logic               rst,
  input wire ivt_pkg::reg_addr_t reg_addr,
  input wire ivt_pkg::data_t     reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire ivt_pkg::data_t     reg_rdata,
  input wire logic               nmi_req,
  input wire logic [7:0]         pin_req,
  input wire logic               irq_valid,
  input wire ivt_pkg::vec_t      irq_vector,
  input wire ivt_pkg::taddr_t    irq_address,
  input wire logic               irq_level
);
  import ivt_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic mode_q;

  // Mirror of the addressing mode; outputs lag it by one cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_MODE) begin
      mode_q <= reg_wdata[MODE_WIDE_BIT];
    end
  end

  property p_rd_quiet;
    reg_rdata != '0 |-> $past(reg_rd);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its slot");
  property p_nmi;
    nmi_req |=> irq_valid && irq_vector == VEC_NMI && irq_level;
  endproperty
  a_nmi: assert property (p_nmi) else $error("pin request not first");
  property p_nmi_addr;
    irq_valid && irq_vector == VEC_NMI |->
      irq_address == ($past(mode_q) ? NMI_ADDR_WIDE : NMI_ADDR_NARROW);
  endproperty
  a_nmi_addr: assert property (p_nmi_addr) else $error("bad pin entry");
  property p_addr;
    irq_valid |-> irq_address == (taddr_t'(irq_vector) << ($past(mode_q) ? 2 : 1));
  endproperty
  a_addr: assert property (p_addr) else $error("bad entry address");
  property p_reserved;
    irq_valid |-> irq_vector inside {7, [16:25], 28, [32:36], [40:47], [64:66], [68:70], [80:91]};
  endproperty
  a_reserved: assert property (p_reserved) else $error("unused vector shown");
  property p_pin0;
    !nmi_req && pin_req[0] |=> irq_valid && (irq_vector == VEC_PIN0 || irq_level);
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 passed over");
  property p_steady;
    irq_valid && $stable(irq_vector) && !$past(reg_wr) && $stable(nmi_req) && nmi_req
      |=> irq_valid && $stable(irq_vector);
  endproperty
  a_steady: assert property (p_steady) else $error("winner dropped");
  property p_level;
    irq_valid && !irq_level |-> irq_vector != VEC_NMI;
  endproperty
  a_level: assert property (p_level) else $error("pin shown at level 0");
  c_nmi: cover property (irq_valid && irq_vector == VEC_NMI);
  c_lvl1: cover property (irq_valid && irq_level && irq_vector != VEC_NMI);
  c_wide: cover property (irq_valid && mode_q);
endmodule

bind ivt_prio ivt_prio_chk i_chk (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .nmi_req, .pin_req, .irq_valid, .irq_vector, .irq_address, .irq_level);

// ==== dv/ivt_prio_tb_top.sv ====
`timescale 1ns/1ps
module ivt_prio_tb_top;
  import ivt_pkg::*;
  logic         mclk, rst, reg_wr, reg_rd, irq_accept, irq_valid, irq_level, mode, mode_s, armed;
  reg_addr_t    reg_addr;
  data_t        reg_wdata, reg_rdata, acc_want;
  vec_t         irq_vector;
  taddr_t       irq_address;
  logic [127:0] rq, rq_s;
  logic [23:0]  lvl, lvl_s;
  logic [8:0]   e;
  int           mismatches, samples_checked;

  ivt_prio i_dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nmi_req(rq[7]), .pin_req(rq[23:16]), .soft_transfer_done_req(rq[24]),
    .watchdog_interval_req(rq[25]), .conversion_end_req(rq[28]), .pt0_req(rq[36:32]),
    .pt1_req(rq[43:40]), .pt2_req(rq[47:44]), .t8_0_req(rq[66:64]), .t8_1_req(rq[70:68]),
    .sp0_req(rq[83:80]), .sp1_req(rq[87:84]), .sp2_req(rq[91:88]), .irq_accept,
    .irq_valid, .irq_vector, .irq_address, .irq_level);
  ivt_core_model i_core (.mclk, .rst, .irq_valid, .irq_accept);

  // Flag that the vector exists, then its group level bit from {A,B,C}
  function automatic logic [1:0] grp(int v, logic [23:0] l);
    case (v) inside
      7: return 2'b11;
      16: return {1'b1, l[23]};
      17: return {1'b1, l[22]};
      [18:19]: return {1'b1, l[21]};
      [20:21]: return {1'b1, l[20]};
      [22:23]: return {1'b1, l[19]};
      24: return {1'b1, l[18]};
      25: return {1'b1, l[17]};
      28: return {1'b1, l[14]};
      [32:36]: return {1'b1, l[13]};
      [40:43]: return {1'b1, l[12]};
      [44:47]: return {1'b1, l[11]};
      [64:66]: return {1'b1, l[7]};
      [68:70]: return {1'b1, l[6]};
      [80:83]: return {1'b1, l[4]};
      [84:87]: return {1'b1, l[3]};
      [88:91]: return {1'b1, l[2]};
      default: return 2'b00;
    endcase
  endfunction

  // Expected {valid, level, vector}: lowest level 1 request, else lowest at all
  function automatic logic [8:0] pick(logic [127:0] r, logic [23:0] l);
    logic [8:0] b0, b1;
    logic [1:0] g;
    b0 = '0;
    b1 = '0;
    for (int v = 127; v >= 0; v--) begin
      g = grp(v, l);
      if (r[v] && g == 2'b11) b1 = {2'b11, 7'(v)};
      if (r[v] && g == 2'b10) b0 = {2'b10, 7'(v)};
    end
    return b1[8] ? b1 : b0;
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wr(reg_addr_t a, data_t d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(reg_addr_t a, output data_t d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  task automatic final_report();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Mirror of the level and mode registers; snapshot of what the design saw
  always @(posedge mclk) begin
    rq_s   <= rq;
    lvl_s  <= lvl;
    mode_s <= mode;
    armed  <= !rst;
    if (rst) begin
      lvl  <= '0;
      mode <= 1'b0;
    end else if (reg_wr && reg_addr < 3'h3) begin
      lvl[23 - 8 * reg_addr -: 8] <= reg_wdata;
    end else if (reg_wr && reg_addr == OFF_MODE) begin
      mode <= reg_wdata[MODE_WIDE_BIT];
    end
  end

  // Outputs judged mid-cycle, once settled
  always @(negedge mclk) begin
    if (armed && !rst) begin
      e = pick(rq_s, lvl_s);
      check(16'(irq_valid), 16'(e[8]));
      if (e[8]) begin
        check(16'(irq_vector), 16'(e[6:0]));
        check(16'(irq_level), 16'(e[7]));
        check(irq_address, 16'(e[6:0]) << (mode_s ? 2 : 1));
      end
    end
  end

  // Expected accepted register, built from the expected choice, not the outputs
  always @(posedge mclk) begin
    if (rst) begin
      acc_want <= 8'h00;
    end else if (irq_accept && e[8]) begin
      acc_want <= {1'b1, e[6:0]};
    end
  end

  initial begin
    #50us;
    mismatches++;
    final_report();
  end

  initial begin
    data_t d, r;
    logic [127:0] corner [3];
    corner = '{'1, ~(128'h1 << 7), 128'h1 << 91};
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, rq} = {1'b1, 141'h0};
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(35910));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    // Every offset reads zero out of reset, unused ones always
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      check(16'(d), 16'h0);
    end
    // Read back; mode keeps one bit, status ignores writes
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      wr(3'(i), d);
      rd(3'(i), r);
      check(16'(r), 16'(i == 3 ? d & 8'h01 : (i == 4 ? 8'h00 : d)));
    end
    // Corners under the pin 2/3 level setting: all at once, all but the pin (vector 7), the very last vector
    wr(OFF_LEVEL_A, 8'h20);
    wr(OFF_LEVEL_B, 8'h00);
    wr(OFF_LEVEL_C, 8'h00);
    foreach (corner[k]) begin
      @(posedge mclk);
      rq <= corner[k];
      repeat (3) @(posedge mclk);
      // Status shows the settled choice while the corner is held
      rd(OFF_STATUS, r);
      check(16'(r), 16'({e[8], e[6:0]}));
    end
    // Sparse random sources, levels and mode, held one to three cycles
    for (int n = 0; n < 600; n++) begin
      if (n % 20 == 0) wr(3'(n / 20 % 4), 8'($urandom));
      @(posedge mclk);
      rq <= {4{$urandom}} & {4{$urandom}} & {$urandom, $urandom, $urandom, $urandom};
      repeat ($urandom_range(0, 2)) @(posedge mclk);
    end
    // Quiet the sources so the last take has settled before it is read
    @(posedge mclk);
    rq <= '0;
    repeat (4) @(posedge mclk);
    rd(OFF_ACCEPTED, r);
    check(16'(r[7]), 16'h1);
    check(16'(r), 16'(acc_want));
    final_report();
  end
endmodule

// ==== verilog/ivt_pkg.sv ====
package ivt_pkg;

  // Widths of the vector, table address and register port
  localparam int VEC_W      = 7;
  localparam int VEC_COUNT  = 128;
  localparam int TADDR_W    = 16;
  localparam int REG_ADDR_W = 3;
  localparam int DATA_W     = 8;

  typedef logic [VEC_W-1:0]      vec_t;
  typedef logic [TADDR_W-1:0]    taddr_t;
  typedef logic [REG_ADDR_W-1:0] reg_addr_t;
  typedef logic [DATA_W-1:0]     data_t;

  // Register offsets on the plain register port
  localparam reg_addr_t OFF_LEVEL_A  = 3'h0;
  localparam reg_addr_t OFF_LEVEL_B  = 3'h1;
  localparam reg_addr_t OFF_LEVEL_C  = 3'h2;
  localparam reg_addr_t OFF_MODE     = 3'h3;
  localparam reg_addr_t OFF_STATUS   = 3'h4;
  localparam reg_addr_t OFF_ACCEPTED = 3'h5;

  // Reset values
  localparam data_t LEVEL_RESET = 8'h00;
  localparam data_t MODE_RESET  = 8'h00;
  localparam vec_t  VEC_RESET   = 7'h00;

  // Field positions
  localparam int MODE_WIDE_BIT  = 0;
  localparam int STAT_VALID_BIT = 7;
  localparam int STAT_LEVEL_BIT = 6;

  // Level bits, register A
  localparam int LVL_PIN0     = 7;
  localparam int LVL_PIN1     = 6;
  localparam int LVL_PIN23    = 5;
  localparam int LVL_PIN45    = 4;
  localparam int LVL_PIN67    = 3;
  localparam int LVL_SOFTDONE = 2;
  localparam int LVL_WATCHDOG = 1;
  // Level bits, register B
  localparam int LVL_CONV = 6;
  localparam int LVL_PT0  = 5;
  localparam int LVL_PT1  = 4;
  localparam int LVL_PT2  = 3;
  // Level bits, register C
  localparam int LVL_T8_0 = 7;
  localparam int LVL_T8_1 = 6;
  localparam int LVL_SP0  = 4;
  localparam int LVL_SP1  = 3;
  localparam int LVL_SP2  = 2;

  // Fixed vector numbers (first vector of each group)
  localparam vec_t VEC_NMI      = 7'h07;
  localparam vec_t VEC_PIN0     = 7'h10;
  localparam vec_t VEC_SOFTDONE = 7'h18;
  localparam vec_t VEC_WATCHDOG = 7'h19;
  localparam vec_t VEC_CONV     = 7'h1c;
  localparam vec_t VEC_PT0      = 7'h20;
  localparam vec_t VEC_PT1      = 7'h28;
  localparam vec_t VEC_PT2      = 7'h2c;
  localparam vec_t VEC_T8_0     = 7'h40;
  localparam vec_t VEC_T8_1     = 7'h44;
  localparam vec_t VEC_SP0      = 7'h50;
  localparam vec_t VEC_SP1      = 7'h54;
  localparam vec_t VEC_SP2      = 7'h58;

  // Table entry offsets for the non-maskable pin
  localparam taddr_t NMI_ADDR_NARROW = 16'h000e;
  localparam taddr_t NMI_ADDR_WIDE   = 16'h001c;

endpackage

// ==== verilog/ivt_prio.sv ====
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ivt_prio (
  input  wire logic             mclk,
  input  wire logic             rst,
  // Register port
  input  wire ivt_pkg::reg_addr_t reg_addr,
  input  wire ivt_pkg::data_t   reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output ivt_pkg::data_t        reg_rdata,
  // Request lines, high while pending
  input  wire logic             nmi_req,
  input  wire logic [7:0]       pin_req,
  input  wire logic             soft_transfer_done_req,
  input  wire logic             watchdog_interval_req,
  input  wire logic             conversion_end_req,
  input  wire logic [4:0]       pt0_req,
  input  wire logic [3:0]       pt1_req,
  input  wire logic [3:0]       pt2_req,
  input  wire logic [2:0]       t8_0_req,
  input  wire logic [2:0]       t8_1_req,
  input  wire logic [3:0]       sp0_req,
  input  wire logic [3:0]       sp1_req,
  input  wire logic [3:0]       sp2_req,
  // Core side
  input  wire logic             irq_accept,
  output logic                  irq_valid,
  output ivt_pkg::vec_t         irq_vector,
  output ivt_pkg::taddr_t       irq_address,
  output logic                  irq_level
);
  import ivt_pkg::*;

  data_t level_register_a;
  data_t level_register_b;
  data_t level_register_c;
  data_t mode_reg;
  vec_t  accepted_vector;
  logic  accepted_seen;

  logic [VEC_COUNT-1:0] req_vec;
  logic [VEC_COUNT-1:0] lvl_vec;

  vec_t   next_vector;
  logic   next_valid;
  logic   next_level;
  taddr_t next_address;
  logic   wide_mode;

  pick_if hi_pick ();
  pick_if any_pick ();

  assign wide_mode = mode_reg[MODE_WIDE_BIT];

  // Level registers and mode bit, written from the register port
  always_ff @(posedge mclk) begin
    if (rst) begin
      level_register_a <= LEVEL_RESET;
      level_register_b <= LEVEL_RESET;
      level_register_c <= LEVEL_RESET;
      mode_reg         <= MODE_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_LEVEL_A: level_register_a <= reg_wdata;
        OFF_LEVEL_B: level_register_b <= reg_wdata;
        OFF_LEVEL_C: level_register_c <= reg_wdata;
        OFF_MODE:    mode_reg         <= reg_wdata & 8'h01;
        default: ;  // Read-only or unmapped: ignored
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= LEVEL_RESET;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFF_LEVEL_A:  reg_rdata <= level_register_a;
        OFF_LEVEL_B:  reg_rdata <= level_register_b;
        OFF_LEVEL_C:  reg_rdata <= level_register_c;
        OFF_MODE:     reg_rdata <= mode_reg;
        OFF_STATUS:   reg_rdata <= {irq_valid, irq_vector};
        OFF_ACCEPTED: reg_rdata <= {accepted_seen, accepted_vector};
        default:      reg_rdata <= LEVEL_RESET;
      endcase
    end else begin
      reg_rdata <= LEVEL_RESET;
    end
  end

  // Place each source but the non-maskable pin at its fixed vector; every other slot stays zero,
  // so reserved numbers can never be selected
  always_comb begin
    req_vec = '0;
    req_vec[VEC_PIN0 +: 8]  = pin_req;
    req_vec[VEC_SOFTDONE]   = soft_transfer_done_req;
    req_vec[VEC_WATCHDOG]   = watchdog_interval_req;
    req_vec[VEC_CONV]       = conversion_end_req;
    req_vec[VEC_PT0 +: 5]   = pt0_req;
    req_vec[VEC_PT1 +: 4]   = pt1_req;
    req_vec[VEC_PT2 +: 4]   = pt2_req;
    req_vec[VEC_T8_0 +: 3]  = t8_0_req;
    req_vec[VEC_T8_1 +: 3]  = t8_1_req;
    req_vec[VEC_SP0 +: 4]   = sp0_req;
    req_vec[VEC_SP1 +: 4]   = sp1_req;
    req_vec[VEC_SP2 +: 4]   = sp2_req;
  end

  // Spread each group's level bit over its vectors; a set bit is level 1
  always_comb begin
    lvl_vec = '0;
    lvl_vec[VEC_PIN0]                 = level_register_a[LVL_PIN0];
    lvl_vec[VEC_PIN0 + 7'h01]         = level_register_a[LVL_PIN1];
    lvl_vec[VEC_PIN0 + 7'h02 +: 2]    = {2{level_register_a[LVL_PIN23]}};
    lvl_vec[VEC_PIN0 + 7'h04 +: 2]    = {2{level_register_a[LVL_PIN45]}};
    lvl_vec[VEC_PIN0 + 7'h06 +: 2]    = {2{level_register_a[LVL_PIN67]}};
    lvl_vec[VEC_SOFTDONE]   = level_register_a[LVL_SOFTDONE];
    lvl_vec[VEC_WATCHDOG]   = level_register_a[LVL_WATCHDOG];
    lvl_vec[VEC_CONV]       = level_register_b[LVL_CONV];
    lvl_vec[VEC_PT0 +: 5]   = {5{level_register_b[LVL_PT0]}};
    lvl_vec[VEC_PT1 +: 4]   = {4{level_register_b[LVL_PT1]}};
    lvl_vec[VEC_PT2 +: 4]   = {4{level_register_b[LVL_PT2]}};
    lvl_vec[VEC_T8_0 +: 3]  = {3{level_register_c[LVL_T8_0]}};
    lvl_vec[VEC_T8_1 +: 3]  = {3{level_register_c[LVL_T8_1]}};
    lvl_vec[VEC_SP0 +: 4]   = {4{level_register_c[LVL_SP0]}};
    lvl_vec[VEC_SP1 +: 4]   = {4{level_register_c[LVL_SP1]}};
    lvl_vec[VEC_SP2 +: 4]   = {4{level_register_c[LVL_SP2]}};
  end

  // Two lowest-number pickers: one over level 1 only, one over all
  assign hi_pick.req  = req_vec & lvl_vec;
  assign any_pick.req = req_vec;

  lowest_pick u_hi_pick (
    .p (hi_pick.chooser)
  );

  lowest_pick u_any_pick (
    .p (any_pick.chooser)
  );

  // Final choice: the pin outranks all, then level 1, then fixed order.
  // Losers are untouched; they stay pending at their sources.
  always_comb begin
    next_valid  = 1'b0;
    next_level  = 1'b0;
    next_vector = VEC_RESET;
    if (nmi_req) begin
      next_valid  = 1'b1;
      next_level  = 1'b1;
      next_vector = VEC_NMI;
    end else if (hi_pick.found) begin
      next_valid  = 1'b1;
      next_level  = 1'b1;
      next_vector = hi_pick.idx;
    end else if (any_pick.found) begin
      next_valid  = 1'b1;
      next_vector = any_pick.idx;
    end
  end

  // Entry address; the pin's offsets are fixed constants for clarity
  always_comb begin
    if (nmi_req) begin
      next_address = wide_mode ? NMI_ADDR_WIDE : NMI_ADDR_NARROW;
    end else if (wide_mode) begin
      next_address = {7'h00, next_vector, 2'b00};
    end else begin
      next_address = {8'h00, next_vector, 1'b0};
    end
  end

  // Presented vector is re-chosen every cycle, so anything that lost
  // is offered again as soon as the winner's source drops
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_valid   <= 1'b0;
      irq_vector  <= VEC_RESET;
      irq_address <= '0;
      irq_level   <= 1'b0;
    end else begin
      irq_valid   <= next_valid;
      irq_vector  <= next_vector;
      irq_address <= next_address;
      irq_level   <= next_level;
    end
  end

  // Record which vector the core took; a take with nothing shown is ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      accepted_vector <= VEC_RESET;
      accepted_seen   <= 1'b0;
    end else if (irq_accept && irq_valid) begin
      accepted_vector <= irq_vector;
      accepted_seen   <= 1'b1;
    end
  end

endmodule

// ==== verilog/lowest_pick.sv ====
`timescale 1ns/1ps
module lowest_pick (
  pick_if.chooser p
);
  import ivt_pkg::*;

  // Scan from the top down so the smallest set index is left standing
  always_comb begin
    p.found = 1'b0;
    p.idx   = VEC_RESET;
    for (int i = VEC_COUNT - 1; i >= 0; i--) begin
      if (p.req[i]) begin
        p.found = 1'b1;
        p.idx   = vec_t'(i);
      end
    end
  end
endmodule

// ==== verilog/pick_if.sv ====
`timescale 1ns/1ps
interface pick_if;
  import ivt_pkg::*;

  logic [VEC_COUNT-1:0] req;
  logic                 found;
  vec_t                 idx;

  modport chooser (input req, output found, output idx);
  modport user    (output req, input found, input idx);
endinterface
